// [logic/pd_params.svh]
/*
  Constants of the power-down mode controller: mode codes, field layout,
  reset values and timing counts.
  Assumes inclusion by bare name from design files.
*/
`ifndef PD_PARAMS_SVH
`define PD_PARAMS_SVH

`define PD_LEVEL_ACTIVE     2'h0
`define PD_LEVEL_LIGHT      2'h1
`define PD_LEVEL_TIMER_DEEP 2'h2
`define PD_LEVEL_DEEPEST    2'h3
`define PD_CTRL_LEVEL_LSB   0
`define PD_CTRL_LEVEL_MSB   1
`define PD_CTRL_GO_BIT      2
`define PD_CTRL_RESET_VAL   3'h0
`define PD_SETTLE_NS        200
`define PD_CLK_PERIOD_NS    100
`define PD_SETTLE_CYCLES    ((`PD_SETTLE_NS + `PD_CLK_PERIOD_NS - 1) / `PD_CLK_PERIOD_NS)

`endif

// [logic/pd_pkg.sv]
/*
  Types of the power-down mode controller.
  Assumes pd_params.svh is compiled alongside.
*/
package pd_pkg;
  typedef enum logic [3:0] {
    ST_ACTIVE = 4'h1,
    ST_ENTER  = 4'h2,
    ST_SLEEP  = 4'h4,
    ST_WAKE   = 4'h8
  } pd_state_t;
endpackage

// [logic/pd_sync_if.sv]
/*
  Carrier for the synchronised wake sources between the top module and
  its wake synchroniser.
  Assumes one system clock.
*/
`timescale 1ns/1ps
interface pd_sync_if;
  logic timer_irq;
  logic ext_irq;
  modport sync_side (output timer_irq, output ext_irq);
  modport ctrl_side (input timer_irq, input ext_irq);
endinterface

// [logic/pd_wake_sync.sv]
/*
  Two-flop synchroniser for the sleep-timer and external wake levels.
  Assumes asynchronous wake inputs and one system clock.
*/
`timescale 1ns/1ps
module pd_wake_sync
(
  input  wire logic   i_clk_sys,
  input  wire logic   i_nrst,
  input  wire logic   i_timer_irq,
  input  wire logic   i_ext_irq,
  pd_sync_if.sync_side sync
);
  logic [1:0] meta_reg;
  logic [1:0] stable_reg;

  always_ff @(posedge i_clk_sys or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      meta_reg   <= 2'h0;
      stable_reg <= 2'h0;
    end
    else
    begin
      meta_reg   <= {i_ext_irq, i_timer_irq};
      stable_reg <= meta_reg;
    end
  end

  assign sync.timer_irq = stable_reg[0];
  assign sync.ext_irq   = stable_reg[1];
endmodule

// [logic/power_down_mode_control.sv]
/*
  Power-down mode controller: holds the sleep control word, enters the
  selected low-power level on a go write and leaves on a permitted wake.
  Assumes the control write strobe comes from same-clock logic; wake
  sources are asynchronous; hardware reset is i_nrst.
*/
//
// Overview of operation
// - Two-bit level field: 0 active, 1 light, 2 timer-wake deep, 3 deepest.
// - Writing go as 1 starts entry into the currently selected level.
// - Levels 1,2 wake on reset, timer or external; level 3 reset or external.
// - Digital regulator on in light sleep, off in deeper; reconfigure after.
`timescale 1ns/1ps
`include "pd_params.svh"
module power_down_mode_control
(
  input  wire logic       i_clk_sys,
  input  wire logic       i_nrst,
  input  wire logic       i_ctrl_wr,
  input  wire logic [2:0] i_ctrl_wdata,
  input  wire logic       i_timer_irq,
  input  wire logic       i_ext_irq,
  output logic      [2:0] o_sleep_control_reg,
  output logic      [1:0] o_active_level,
  output logic            o_sleeping,
  output logic            o_clk_gate,
  output logic            o_dig_reg_on,
  output logic            o_reconfig_needed,
  output logic            o_wake_pulse
);
  localparam int SETTLE = `PD_SETTLE_CYCLES;

  pd_sync_if sync ();

  pd_wake_sync u_wake_sync
  (
    .i_clk_sys   (i_clk_sys),
    .i_nrst      (i_nrst),
    .i_timer_irq (i_timer_irq),
    .i_ext_irq   (i_ext_irq),
    .sync        (sync)
  );

  pd_pkg::pd_state_t state_reg;
  pd_pkg::pd_state_t state_next;
  logic [1:0]        sleep_level_select_reg;
  logic              sleep_entry_go_reg;
  logic [1:0]        level_reg;
  logic [2:0]        settle_reg;
  logic              wake_ok;
  logic              go_write;
  logic              deep_level;

  assign go_write   = i_ctrl_wr && i_ctrl_wdata[`PD_CTRL_GO_BIT];
  assign deep_level = (level_reg == `PD_LEVEL_TIMER_DEEP) ||
                      (level_reg == `PD_LEVEL_DEEPEST);

  // Permitted wake source for the level held
  always_comb
  begin
    case (level_reg)
      `PD_LEVEL_LIGHT,
      `PD_LEVEL_TIMER_DEEP: wake_ok = sync.timer_irq || sync.ext_irq;
      `PD_LEVEL_DEEPEST:    wake_ok = sync.ext_irq;
      default:              wake_ok = 1'b0;
    endcase
  end

  // Level field written by software
  always_ff @(posedge i_clk_sys or negedge i_nrst)
  begin
    if (!i_nrst)
      sleep_level_select_reg <= 2'h0;
    else if (i_ctrl_wr)
      sleep_level_select_reg <= i_ctrl_wdata[`PD_CTRL_LEVEL_MSB:`PD_CTRL_LEVEL_LSB];
  end

  // Go bit: set by write, cleared by wake
  always_ff @(posedge i_clk_sys or negedge i_nrst)
  begin
    if (!i_nrst)
      sleep_entry_go_reg <= 1'b0;
    else if (go_write && state_reg == pd_pkg::ST_ACTIVE)
      sleep_entry_go_reg <= 1'b1;
    else if (state_reg == pd_pkg::ST_SLEEP && wake_ok)
      sleep_entry_go_reg <= 1'b0;
    else if (state_reg == pd_pkg::ST_ACTIVE)
      sleep_entry_go_reg <= 1'b0;
  end

  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      pd_pkg::ST_ACTIVE:
        if (go_write && i_ctrl_wdata[1:0] != `PD_LEVEL_ACTIVE)
          state_next = pd_pkg::ST_ENTER;
      pd_pkg::ST_ENTER:
        if (settle_reg == 3'h0)
          state_next = pd_pkg::ST_SLEEP;
      pd_pkg::ST_SLEEP:
        if (wake_ok)
          state_next = pd_pkg::ST_WAKE;
      pd_pkg::ST_WAKE:
        state_next = pd_pkg::ST_ACTIVE;
      default:
        state_next = pd_pkg::ST_ACTIVE;
    endcase
  end

  always_ff @(posedge i_clk_sys or negedge i_nrst)
  begin
    if (!i_nrst)
      state_reg <= pd_pkg::ST_ACTIVE;
    else
      state_reg <= state_next;
  end

  // Level latched at entry; settle countdown
  always_ff @(posedge i_clk_sys or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      level_reg  <= 2'h0;
      settle_reg <= 3'h0;
    end
    else if (state_reg == pd_pkg::ST_ACTIVE && state_next == pd_pkg::ST_ENTER)
    begin
      level_reg  <= i_ctrl_wdata[1:0];
      settle_reg <= 3'(SETTLE - 1);
    end
    else if (state_reg == pd_pkg::ST_ENTER && settle_reg != 3'h0)
      settle_reg <= settle_reg - 3'h1;
    else if (state_reg == pd_pkg::ST_WAKE)
      level_reg  <= 2'h0;
  end

  // Outputs, all registered
  always_ff @(posedge i_clk_sys or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      o_sleep_control_reg <= `PD_CTRL_RESET_VAL;
      o_active_level      <= 2'h0;
      o_sleeping          <= 1'b0;
      o_clk_gate          <= 1'b0;
      o_dig_reg_on        <= 1'b1;
      o_reconfig_needed   <= 1'b0;
      o_wake_pulse        <= 1'b0;
    end
    else
    begin
      o_sleep_control_reg <= {sleep_entry_go_reg, sleep_level_select_reg};
      o_active_level      <= level_reg;
      o_sleeping          <= (state_reg == pd_pkg::ST_SLEEP);
      o_clk_gate          <= (state_reg == pd_pkg::ST_SLEEP);
      o_dig_reg_on        <= !(state_reg == pd_pkg::ST_SLEEP && deep_level);
      o_wake_pulse        <= (state_reg == pd_pkg::ST_SLEEP && wake_ok);
      if (state_reg == pd_pkg::ST_SLEEP && wake_ok && deep_level)
        o_reconfig_needed <= 1'b1;
      else if (i_ctrl_wr)
        o_reconfig_needed <= 1'b0;
    end
  end

  sequence s_sleep_deep;
    state_reg == pd_pkg::ST_SLEEP && deep_level;
  endsequence

  sequence s_regulator_off;
    !o_dig_reg_on;
  endsequence

  a_go_starts_entry: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
    (state_reg == pd_pkg::ST_ACTIVE && go_write && i_ctrl_wdata[1:0] != 2'h0)
      |=> state_reg == pd_pkg::ST_ENTER)
    else $error("go write did not start entry");

  a_deepest_no_timer: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
    (state_reg == pd_pkg::ST_SLEEP && level_reg == 2'h3 && !sync.ext_irq)
      |=> state_reg == pd_pkg::ST_SLEEP)
    else $error("deepest level woke without external source");

  a_wake_on_source: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
    (state_reg == pd_pkg::ST_SLEEP && level_reg != 2'h3 && sync.timer_irq)
      |=> state_reg == pd_pkg::ST_WAKE ##1 state_reg == pd_pkg::ST_ACTIVE)
    else $error("timer wake not honoured");

  a_regulator_deep_off: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
    s_sleep_deep |=> s_regulator_off)
    else $error("regulator on in deep level");

  a_regulator_light_on: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
    (state_reg == pd_pkg::ST_SLEEP && level_reg == 2'h1) |=> o_dig_reg_on)
    else $error("regulator off in light level");

  a_go_self_clear: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
    (state_reg == pd_pkg::ST_SLEEP && wake_ok) |=> ##1 !o_sleep_control_reg[2])
    else $error("go bit not cleared after wake");

  a_level_decode: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
    i_ctrl_wr |=> sleep_level_select_reg == $past(i_ctrl_wdata[1:0]))
    else $error("level field not stored");

  a_active_no_entry: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
    (state_reg == pd_pkg::ST_ACTIVE && go_write && i_ctrl_wdata[1:0] == 2'h0)
      |=> state_reg == pd_pkg::ST_ACTIVE)
    else $error("level 0 entered sleep");
endmodule

// [dv/power_down_mode_control_test.sv]
/*
  Self-checking bench for the power-down mode controller.
  Assumes pd_params.svh is on the include path; the bench drives every port.
*/
`timescale 1ns/1ps
`include "pd_params.svh"
`define CHECK(nm, ex, got) begin comparisons++; if ((got) !== (ex)) begin n_errors++; \
  $display("[FAIL] %s expected %0h seen %0h", nm, ex, got); end end
module power_down_mode_control_test;
  logic       i_clk_sys;
  logic       i_nrst;
  logic       i_ctrl_wr;
  logic [2:0] i_ctrl_wdata;
  logic       i_timer_irq;
  logic       i_ext_irq;
  logic [2:0] o_sleep_control_reg;
  logic [1:0] o_active_level;
  logic       o_sleeping;
  logic       o_clk_gate;
  logic       o_dig_reg_on;
  logic       o_reconfig_needed;
  logic       o_wake_pulse;
  int         n_errors;
  int         comparisons;
  int         cycles;
  logic [7:0] lfsr_reg;

  power_down_mode_control DUT
  (
    .i_clk_sys           (i_clk_sys),
    .i_nrst              (i_nrst),
    .i_ctrl_wr           (i_ctrl_wr),
    .i_ctrl_wdata        (i_ctrl_wdata),
    .i_timer_irq         (i_timer_irq),
    .i_ext_irq           (i_ext_irq),
    .o_sleep_control_reg (o_sleep_control_reg),
    .o_active_level      (o_active_level),
    .o_sleeping          (o_sleeping),
    .o_clk_gate          (o_clk_gate),
    .o_dig_reg_on        (o_dig_reg_on),
    .o_reconfig_needed   (o_reconfig_needed),
    .o_wake_pulse        (o_wake_pulse)
  );

  function logic [7:0] lfsr_next(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction

  function logic exp_reg_on(input logic [1:0] lvl);
    return lvl == `PD_LEVEL_LIGHT;
  endfunction

  task finish_test;
    if (n_errors == 0 && comparisons > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task tick;
    @(posedge i_clk_sys);
    #10;
  endtask

  task wr(input logic [2:0] d);
    i_ctrl_wr = 1'b1;
    i_ctrl_wdata = d;
    tick;
    i_ctrl_wr = 1'b0;
  endtask

  task sleep_cycle(input logic [1:0] lvl, input logic use_timer);
    int k;
    k = 0;
    wr({1'b1, lvl});
    while (o_sleeping !== 1'b1 && k < 10)
    begin
      tick;
      k++;
    end
    `CHECK("sleeping", 1'b1, o_sleeping)
    `CHECK("clk_gate", 1'b1, o_clk_gate)
    `CHECK("level", lvl, o_active_level)
    `CHECK("ctrl", {1'b1, lvl}, o_sleep_control_reg)
    `CHECK("reg_on", exp_reg_on(lvl), o_dig_reg_on)
    // Write while asleep: only the level field moves
    wr({1'b1, ~lvl});
    tick;
    `CHECK("slp_wr_stay", 1'b1, o_sleeping)
    `CHECK("slp_wr_level", lvl, o_active_level)
    `CHECK("slp_wr_ctrl", {1'b1, ~lvl}, o_sleep_control_reg)
    if (use_timer)
      i_timer_irq = 1'b1;
    else
      i_ext_irq = 1'b1;
    if (use_timer && lvl == `PD_LEVEL_DEEPEST)
    begin
      repeat (6) tick;
      `CHECK("timer_ignored", 1'b1, o_sleeping)
      i_ext_irq = 1'b1;
    end
    k = 0;
    while (o_wake_pulse !== 1'b1 && k < 10)
    begin
      tick;
      k++;
    end
    `CHECK("wake_pulse", 1'b1, o_wake_pulse)
    tick;
    `CHECK("woke", 1'b0, o_sleeping)
    `CHECK("pulse_end", 1'b0, o_wake_pulse)
    i_timer_irq = 1'b0;
    i_ext_irq = 1'b0;
    repeat (4) tick;
    `CHECK("go_clear", 1'b0, o_sleep_control_reg[2])
    `CHECK("reg_back", 1'b1, o_dig_reg_on)
    `CHECK("level_back", 2'h0, o_active_level)
    `CHECK("reconfig", lvl != `PD_LEVEL_LIGHT, o_reconfig_needed)
    wr({1'b1, `PD_LEVEL_ACTIVE});
    repeat (6) tick;
    `CHECK("no_sleep_l0", 1'b0, o_sleeping)
    `CHECK("ctrl_l0", {1'b0, `PD_LEVEL_ACTIVE}, o_sleep_control_reg)
    `CHECK("reconfig_clr", 1'b0, o_reconfig_needed)
  endtask

  initial
  begin
    i_clk_sys = 1'b0;
    forever #50 i_clk_sys = ~i_clk_sys;
  end

  always @(posedge i_clk_sys)
  begin
    cycles++;
    if (cycles > 5000)
    begin
      n_errors++;
      finish_test;
    end
  end

  initial
  begin
    {i_nrst, i_ctrl_wr, i_ctrl_wdata, i_timer_irq, i_ext_irq} = 7'h00;
    lfsr_reg = 8'h48;
    repeat (10) @(posedge i_clk_sys);
    #10;
    `CHECK("rst_ctrl", `PD_CTRL_RESET_VAL, o_sleep_control_reg)
    `CHECK("rst_sleep", 1'b0, o_sleeping)
    `CHECK("rst_reg_on", 1'b1, o_dig_reg_on)
    i_nrst = 1'b1;
    tick;
    for (int l = 1; l < 4; l++)
      for (int t = 0; t < 2; t++)
        sleep_cycle(l[1:0], t[0]);
    repeat (12)
    begin
      lfsr_reg = lfsr_next(lfsr_reg);
      sleep_cycle((lfsr_reg[1:0] == 2'h0) ? 2'h1 : lfsr_reg[1:0], lfsr_reg[2]);
    end
    wr({1'b1, `PD_LEVEL_DEEPEST});
    repeat (6) tick;
    i_nrst = 1'b0;
    tick;
    `CHECK("rst_wake", 1'b0, o_sleeping)
    `CHECK("rst_wake_reg", 1'b1, o_dig_reg_on)
    i_nrst = 1'b1;
    tick;
    finish_test;
  end
endmodule
